/* File: src/led_pwm_global_control.sv */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module led_pwm_global_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] com_out,
    output logic active_page
);

    logic [5:0] ctrl_r;
    logic [5:0] ctrl_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [7:0] pga_en_r;
    logic [7:0] pga_en_nxt;
    logic [7:0] pga_duty_r;
    logic [7:0] pga_duty_nxt;
    logic [7:0] pgb_en_r;
    logic [7:0] pgb_en_nxt;
    logic [7:0] pgb_duty_r;
    logic [7:0] pgb_duty_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic page_r;
    logic page_nxt;
    logic [7:0] ramp_r;
    logic [7:0] ramp_nxt;
    logic [7:0] com_r;
    logic [7:0] com_nxt;

    logic en;
    logic pol;
    logic dir;
    logic frame_end;
    logic [7:0] mask;
    logic [7:0] duty_sel;
    logic [7:0] eff_duty;
    logic [7:0] lit;
    logic [31:0] rd_data;
    logic map_ok;
    logic acc;

    assign en = ctrl_r[led_pwm_pkg::CTRL_EN_BIT];
    assign pol = ctrl_r[led_pwm_pkg::CTRL_POL_BIT];
    assign dir = ctrl_r[led_pwm_pkg::CTRL_DIR_BIT];
    assign acc = psel & penable;

    // Read multiplexer and address decode; unmapped offsets read zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        map_ok = 1'b1;
        unique case (paddr)
            led_pwm_pkg::CTRL_OFS: rd_data = {26'h0, ctrl_r};
            led_pwm_pkg::MODE_OFS: rd_data = {30'h0, mode_r};
            led_pwm_pkg::PGA_EN_OFS: rd_data = {24'h0, pga_en_r};
            led_pwm_pkg::PGA_DUTY_OFS: rd_data = {24'h0, pga_duty_r};
            led_pwm_pkg::PGB_EN_OFS: rd_data = {24'h0, pgb_en_r};
            led_pwm_pkg::PGB_DUTY_OFS: rd_data = {24'h0, pgb_duty_r};
            led_pwm_pkg::STATUS_OFS: begin
                rd_data = {8'h00, cnt_r, ramp_r, 7'h00, page_r};
            end
            default: map_ok = 1'b0;
        endcase
    end

    // Bus slave: one wait state, so the answer leaves a flip-flop.
    // Writes land on the edge where pready is seen high.
    always_comb begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        pga_en_nxt = pga_en_r;
        pga_duty_nxt = pga_duty_r;
        pgb_en_nxt = pgb_en_r;
        pgb_duty_nxt = pgb_duty_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = acc & ~pready_r;
        if (acc && !pready_r) begin
            prdata_nxt = pwrite ? 32'h0000_0000 : rd_data;
            pslverr_nxt = ~map_ok;
        end
        if (acc && pready_r && pwrite) begin
            unique case (paddr)
                led_pwm_pkg::CTRL_OFS: ctrl_nxt = pwdata[5:0];
                led_pwm_pkg::MODE_OFS: mode_nxt = pwdata[1:0];
                led_pwm_pkg::PGA_EN_OFS: pga_en_nxt = pwdata[7:0];
                led_pwm_pkg::PGA_DUTY_OFS: pga_duty_nxt = pwdata[7:0];
                led_pwm_pkg::PGB_EN_OFS: pgb_en_nxt = pwdata[7:0];
                led_pwm_pkg::PGB_DUTY_OFS: pgb_duty_nxt = pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Register state of the bus slave.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= led_pwm_pkg::CTRL_RST;
            mode_r <= led_pwm_pkg::MODE_RST;
            pga_en_r <= led_pwm_pkg::PG_EN_RST;
            pga_duty_r <= led_pwm_pkg::PG_DUTY_RST;
            pgb_en_r <= led_pwm_pkg::PG_EN_RST;
            pgb_duty_r <= led_pwm_pkg::PG_DUTY_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            pga_en_r <= pga_en_nxt;
            pga_duty_r <= pga_duty_nxt;
            pgb_en_r <= pgb_en_nxt;
            pgb_duty_r <= pgb_duty_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Page contents in use come only from the latched page.
    assign mask = page_r ? pgb_en_r : pga_en_r;
    assign duty_sel = page_r ? pgb_duty_r : pga_duty_r;
    assign eff_duty = (mode_r == led_pwm_pkg::MODE_RAMP) ? ramp_r : duty_sel;
    assign frame_end = en && (cnt_r == led_pwm_pkg::FRAME_LAST);

    // PWM engine. The page is re-sampled only when a frame closes, so a
    // page switch in mid-frame never tears the picture. While disabled no
    // frame runs, so the selector is simply followed.
    always_comb begin
        cnt_nxt = en ? cnt_r + 8'h01 : 8'h00;
        page_nxt = page_r;
        if (!en || frame_end) begin
            page_nxt = ctrl_r[led_pwm_pkg::CTRL_PSEL_BIT];
        end
        ramp_nxt = ramp_r;
        if (mode_r != led_pwm_pkg::MODE_RAMP) begin
            ramp_nxt = duty_sel;
        end else if (frame_end) begin
            if (dir && ramp_r != led_pwm_pkg::DUTY_MAX) begin
                ramp_nxt = ramp_r + 8'h01;
            end else if (!dir && ramp_r != led_pwm_pkg::DUTY_MIN) begin
                ramp_nxt = ramp_r - 8'h01;
            end
        end
        lit = {8{en && (cnt_r < eff_duty)}} & mask;
        com_nxt = pol ? lit : ~lit;
    end

    // Register state of the PWM engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            page_r <= 1'b0;
            ramp_r <= led_pwm_pkg::PG_DUTY_RST;
            com_r <= led_pwm_pkg::COM_RST;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            page_r <= page_nxt;
            ramp_r <= ramp_nxt;
            com_r <= com_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign com_out = com_r;
    assign active_page = page_r;

    // Disabled hardware holds every common line at its idle level.
    a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !en) |=> (com_out == {8{~$past(pol)}}))
        else $error("Common lines not idle while disabled.");

    // A lit line shows the active level chosen by polarity.
    a_lit_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && en && mask[0] && cnt_r < eff_duty)
        |=> (com_out[0] == $past(pol)))
        else $error("Lit common line has wrong polarity.");

    // Ramp up adds one per frame below the top.
    a_ramp_up: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && frame_end && mode_r == led_pwm_pkg::MODE_RAMP && dir
         && ramp_r != led_pwm_pkg::DUTY_MAX)
        |=> (ramp_r == $past(ramp_r) + 8'h01))
        else $error("Ramp did not step up.");

    // Ramp down takes one per frame above the bottom.
    a_ramp_down: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && frame_end && mode_r == led_pwm_pkg::MODE_RAMP && !dir
         && ramp_r != led_pwm_pkg::DUTY_MIN)
        |=> (ramp_r == $past(ramp_r) - 8'h01))
        else $error("Ramp did not step down.");

    // A line masked off on page B stays dark while page B is active.
    a_page_b_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && en && page_r && !pgb_en_r[0])
        |=> (com_out[0] == ~$past(pol)))
        else $error("Page B mask not honoured.");

    // At a frame end the page takes the selector's value.
    a_page_sample: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && frame_end)
        |=> (page_r == $past(ctrl_r[led_pwm_pkg::CTRL_PSEL_BIT])))
        else $error("Page not sampled at frame end.");

    // Within a running frame the page never moves.
    a_page_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && en && !frame_end) |=> $stable(page_r))
        else $error("Page changed in mid-frame.");

    // The answer is a single-cycle pulse, so no transfer is taken twice.
    a_ready_pulse: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && pready) |=> !pready)
        else $error("Ready held for more than one cycle.");

    // Exactly one wait state follows the first access edge.
    a_ready_wait: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && acc && !pready) |=> pready)
        else $error("Ready missing after the wait state.");

    // An offset outside the map answers with an error.
    a_err_unmapped: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && acc && !pready && !map_ok) |=> pslverr)
        else $error("Unmapped offset answered without error.");

    // The error flag only ever rides on the answer.
    a_err_with_ready: assert property (@(posedge pclk)
        disable iff (!presetn) pslverr |-> pready)
        else $error("Error flag seen without ready.");

    // Read data is the addressed register as it stood at the access.
    a_read_data: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && acc && !pready && !pwrite)
        |=> (prdata == $past(rd_data)))
        else $error("Read data does not match the register.");

    // A write to the control register lands at the completing edge.
    a_ctrl_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (ce && acc && pready && pwrite && paddr == led_pwm_pkg::CTRL_OFS)
        |=> (ctrl_r == $past(pwdata[5:0])))
        else $error("Control write did not land.");

    // A low clock enable freezes the engine and the bus answer alike.
    a_ce_freeze: assert property (@(posedge pclk)
        disable iff (!presetn)
        !ce |=> ($stable(cnt_r) && $stable(com_out) && $stable(pready)))
        else $error("State moved while the clock enable was low.");

    // Disabled hardware keeps the frame counter parked at zero.
    a_cnt_parked: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && !en) |=> (cnt_r == 8'h00))
        else $error("Frame counter ran while disabled.");

    // The ramp saturates at the top rather than wrapping to dark.
    a_ramp_top: assert property (@(posedge pclk)
        disable iff (!presetn)
        (ce && frame_end && mode_r == led_pwm_pkg::MODE_RAMP && dir
         && ramp_r == led_pwm_pkg::DUTY_MAX) |=> $stable(ramp_r))
        else $error("Ramp wrapped past the top.");

    // The ramp saturates at the bottom rather than wrapping to full.
    a_ramp_bottom: assert property (@(posedge pclk)
        disable iff (!presetn)
        (ce && frame_end && mode_r == led_pwm_pkg::MODE_RAMP && !dir
         && ramp_r == led_pwm_pkg::DUTY_MIN) |=> $stable(ramp_r))
        else $error("Ramp wrapped past the bottom.");

    // While disabled no frame runs, so the page follows the selector.
    a_page_follow: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && !en)
        |=> (page_r == $past(ctrl_r[led_pwm_pkg::CTRL_PSEL_BIT])))
        else $error("Page did not follow the selector while disabled.");

    // Past the duty point every line shows its idle level.
    a_dark_past_duty: assert property (@(posedge pclk)
        disable iff (!presetn) (ce && en && cnt_r >= eff_duty)
        |=> (com_out == {8{~$past(pol)}}))
        else $error("Line lit beyond its duty.");

endmodule

/* File: src/led_pwm_pkg.sv */
package led_pwm_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MODE_OFS = 8'h04;
    localparam logic [7:0] PGA_EN_OFS = 8'h08;
    localparam logic [7:0] PGA_DUTY_OFS = 8'h0c;
    localparam logic [7:0] PGB_EN_OFS = 8'h10;
    localparam logic [7:0] PGB_DUTY_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // Field positions of the global control register.
    localparam int CTRL_PSEL_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_RSV_LSB = 2;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_POL_BIT = 5;
    localparam int CTRL_W = 6;

    // Reset values; the reserved field resets to its required pattern.
    localparam logic [5:0] CTRL_RST = 6'h04;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] PG_EN_RST = 8'h00;
    localparam logic [7:0] PG_DUTY_RST = 8'h00;
    // Common lines leave reset dark, since the reset polarity is active low.
    localparam logic [7:0] COM_RST = 8'hff;

    // PWM mode field encodings.
    localparam logic [1:0] MODE_STATIC = 2'h0;
    localparam logic [1:0] MODE_RAMP = 2'h1;

    // One frame is a full sweep of the duty counter.
    localparam logic [7:0] FRAME_LAST = 8'hff;
    localparam logic [7:0] DUTY_MAX = 8'hff;
    localparam logic [7:0] DUTY_MIN = 8'h00;

endpackage

/* File: testbench/led_matrix_model.sv */
`timescale 1ns/1ps
// Stands in for the matrix and counts the cycles each common line is lit.
module led_matrix_model (
    input wire logic pclk,
    input wire logic clr,
    input wire logic pol,
    input wire logic [7:0] com,
    output int lit [8]
);
    // A line is lit when it sits at the active level; unknowns never count.
    always @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            lit[i] <= clr ? 0 : lit[i] + int'(com[i] === pol);
        end
    end
endmodule

/* File: testbench/led_pwm_global_control_tb.sv */
`timescale 1ns/1ps
module led_pwm_global_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] com_out;
    logic active_page;
    logic ce = 1'b1;
    logic clr = 1'b1;
    logic pol = 1'b0;
    int lit [8];
    int failures = 0;
    int check_count = 0;
    int n;
    logic [31:0] mdl [7];
    logic [31:0] q;
    logic e;
    logic [7:0] s1;
    logic [16:0] rnd = 17'h1_2e03;

    led_pwm_global_control dut_u (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .com_out(com_out), .active_page(active_page));
    led_matrix_model matrix_u (.pclk(pclk), .clr(clr), .pol(pol),
        .com(com_out), .lit(lit));

    // Free-running bus clock.
    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; an idle edge follows so strobes never re-assert at once.
    // Ready and data are read right after the edge, before the slave's
    // flip-flops update, so they are the values that edge sampled.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        er = pslverr;
        if (pready !== 1'b1) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a != led_pwm_pkg::STATUS_OFS) mdl[a >> 2] = d;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, q, e);
        chk(q, mdl[a >> 2]);
        chk({31'h0, e}, 32'h0);
    endtask

    // Lit cycles over one full sweep follow the active page's mask and duty.
    task automatic count_frame(input int pg);
        repeat (260) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (256) @(posedge pclk);
        @(negedge pclk);
        for (int i = 0; i < 8; i++) begin
            chk(lit[i], mdl[2 + 2 * pg][i] ? mdl[3 + 2 * pg] : 0);
        end
        @(posedge pclk);
    endtask

    // Random source for the stimulus.
    function automatic logic [16:0] lfsr(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction

    function automatic logic [31:0] ctrl(logic p, logic d, logic en, logic s);
        return {26'h0, p, d, 2'b01, en, s};
    endfunction

    // Main sequence.
    initial begin
        mdl = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 6; a++) rd(8'(a * 4));
        apb(1'b0, 8'h1c, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        rnd = lfsr(rnd);
        wr(led_pwm_pkg::PGA_EN_OFS, 32'hff);
        wr(led_pwm_pkg::PGA_DUTY_OFS, 32'h10);
        wr(led_pwm_pkg::PGB_EN_OFS, {24'h0, rnd[7:0]});
        wr(led_pwm_pkg::PGB_DUTY_OFS, 32'h80);
        for (int a = 0; a < 6; a++) rd(8'(a * 4));
        for (int p = 0; p < 2; p++) begin
            wr(led_pwm_pkg::CTRL_OFS, ctrl(p[0], 1'b0, 1'b0, 1'b0));
            @(negedge pclk);
            chk({24'h0, com_out}, {24'h0, {8{~p[0]}}});
            @(posedge pclk);
        end
        wr(led_pwm_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b1, 1'b0));
        count_frame(0);
        n = 0;
        // Switch pages just after a frame starts; the old page must hold.
        do begin
            @(negedge pclk);
            n++;
        end while (com_out[0] !== 1'b0 && n < 300);
        @(posedge pclk);
        wr(led_pwm_pkg::CTRL_OFS, ctrl(1'b0, 1'b0, 1'b1, 1'b1));
        n = 0;
        @(negedge pclk);
        chk({31'h0, active_page}, 32'h0);
        while (active_page !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, n > 200 && n <= 256}, 32'h1);
        @(posedge pclk);
        pol <= 1'b1;
        wr(led_pwm_pkg::CTRL_OFS, ctrl(1'b1, 1'b0, 1'b1, 1'b1));
        count_frame(1);
        wr(led_pwm_pkg::MODE_OFS, {30'h0, led_pwm_pkg::MODE_RAMP});
        for (int d = 0; d < 2; d++) begin
            wr(led_pwm_pkg::CTRL_OFS, ctrl(1'b1, d[0], 1'b1, 1'b1));
            apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0, q, e);
            s1 = q[15:8];
            repeat (252) @(posedge pclk);
            apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0, q, e);
            chk({24'h0, q[15:8]}, {24'h0, d ? s1 + 8'h01 : s1 - 8'h01});
        end
        // Twenty frozen edges between two reads leave four counted ones.
        apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0, q, e);
        s1 = q[23:16];
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0, q, e);
        chk({24'h0, q[23:16]}, {24'h0, s1 + 8'h04});
        close_out();
    end

    // Cuts a hang short well beyond the few thousand cycles the run needs.
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        close_out();
    end
endmodule
